// file: cesc_chk.sv
/*
 * assertions on the stage pair ports: registers, decode, sequencer.
 * assumes the bind below and one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cesc_chk (
   input wire logic                 CORE_CLK,
   input wire logic                 ARST_N,
   input wire logic [7:0]           REG_ADDR,
   input wire logic [7:0]           REG_WDATA,
   input wire logic                 REG_WR,
   input wire logic [7:0]           REG_RDATA,
   input wire logic                 SEQ_START,
   input wire logic                 PROFILE_BC12,
   input wire cesc_pkg::cesc_pins_s PIN_CTRL,
   input wire logic [11:0]          TH_MV,
   input wire logic [7:0]           SINK_UA,
   input wire logic [2:0]           DIV_RATIO,
   input wire logic                 STAGE_SEL,
   input wire logic                 SEQ_DONE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!ARST_N);

   // ****************
   // register port
   // ****************
   // response write, then an idle cycle
   sequence s_resp_wr(rsv);
      REG_WR && REG_ADDR == cesc_pkg::OFS_S2_RESP && (REG_WDATA[7:4] == 4'hf) == rsv
         ##1 REG_ADDR == cesc_pkg::OFS_S2_RESP && !REG_WR;
   endsequence
   a_resp_accept: assert property (s_resp_wr(1'b0) |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("write not read back");
   a_resp_reject: assert property (s_resp_wr(1'b1) |=> $stable(REG_RDATA))
      else $error("reserved write took effect");
   a_rd_unmapped: assert property (!($past(REG_ADDR) inside {[8'h45:8'h4b]}) |-> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_ratio_bits: assert property ($past(REG_ADDR) == cesc_pkg::OFS_S2_RATIO |-> REG_RDATA[7:3] == 5'h00)
      else $error("ratio pad bits set");

   // ****************
   // decode outputs
   // ****************
   a_ratio_legal: assert property (DIV_RATIO != 3'h7)
      else $error("reserved ratio on output");
   a_ratio_frozen: assert property (PROFILE_BC12 && $past(PROFILE_BC12) && $past(PROFILE_BC12, 2) |-> $stable(DIV_RATIO))
      else $error("ratio moved in charging");
   a_th_frozen: assert property (!PROFILE_BC12 && !$past(PROFILE_BC12) && !$past(PROFILE_BC12, 2) |-> $stable(TH_MV))
      else $error("threshold moved in legacy");
   a_sink_frozen: assert property (!PROFILE_BC12 && !$past(PROFILE_BC12) && !$past(PROFILE_BC12, 2) |-> $stable(SINK_UA))
      else $error("sink moved in legacy");
   a_sink_legal: assert property (SINK_UA inside {8'h00, 8'h0a, 8'h32, 8'h64, 8'h96})
      else $error("sink off table");

   // ****************
   // sequencer
   // ****************
   a_start_pulldowns: assert property (SEQ_START && SEQ_DONE |=> PIN_CTRL.plus_pd && PIN_CTRL.minus_pd && !STAGE_SEL && !SEQ_DONE)
      else $error("restart without pull-downs");
   a_done_after_s3: assert property ($rose(SEQ_DONE) |-> $past(STAGE_SEL))
      else $error("done without stage 3");
endmodule

bind cesc_top cesc_chk cesc_chk_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .SEQ_START(SEQ_START), .PROFILE_BC12(PROFILE_BC12), .PIN_CTRL(PIN_CTRL),
   .TH_MV(TH_MV), .SINK_UA(SINK_UA), .DIV_RATIO(DIV_RATIO), .STAGE_SEL(STAGE_SEL), .SEQ_DONE(SEQ_DONE));
`default_nettype wire

// file: cesc_pkg.sv
/*
 * package for the custom emulation stimulus configuration block: register
 * offsets, field positions, codes, decode tables and carrier structs.
 * assumes one 10 MHz core clock and a register access port.
 */
// Operation
// - response 0000 clears both pins; 0001/0010/0011 apply voltage plus/minus/both.
// - 0100 resistor plus-ground, 0111 minus-ground, 1101 both pins to ground.
// - 0110/1001/1100 connect divider with midpoint on plus/minus/both.
// - 1010 shorts plus to minus through low resistance; 0101/1000/1011 reserved.
// - 1110/1111 keep reset pull-downs if stimulus 000, remove if 111.
// - single-pin response keeps reset pull-down only if stage1 is 000 and pin free.
// - bits 5-4 pick sink current 10/50/100/150 uA for pull-down voltage.
// - threshold ignored when stimulus selection is 000 or 111.
// - bits 3-0 decode threshold 300..2200 mV; 1111 reserved.
// - threshold and sink current only used by charging profiles.
// - bits 2-0 select divider ratio 0.25..0.66; 111 reserved.
// - divider ratio only used by legacy profiles.
// - timer type 1 holds response for timer; 0 delays response.
// - bits 5-3 select timer 0/1/5/10/20/40/80/100 ms.
// - stimulus 000 waits bus ready, 111 bus present; no wait for removal.
// - 001/110 plus above threshold, 011 minus above; 100/101 reserved.
// - 010 triggers on plus inside window above fixed 400 mV floor.
// - writes with reserved magnitude are rejected, old value kept.
package cesc_pkg;

   localparam int unsigned CLK_HZ     = 10_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // ****************************************************
   // register map
   // ****************************************************
   localparam logic [7:0] OFS_S2_STIM_TMR = 8'h45;
   localparam logic [7:0] OFS_S2_RESP     = 8'h46;
   localparam logic [7:0] OFS_S2_TH_PD    = 8'h47;
   localparam logic [7:0] OFS_S2_RATIO    = 8'h48;
   localparam logic [7:0] OFS_S3_STIM_TMR = 8'h49;
   localparam logic [7:0] OFS_S3_RESP     = 8'h4a;
   localparam logic [7:0] OFS_S3_TH_PD    = 8'h4b;
   localparam logic [7:0] REG_RESET       = 8'h00;

   // field positions
   localparam int TYPE_BIT  = 6;
   localparam int TMR_LSB   = 3;
   localparam int STIM_LSB  = 0;
   localparam int MAG_LSB   = 4;
   localparam int CODE_LSB  = 0;
   localparam int SINK_LSB  = 4;
   localparam int TH_LSB    = 0;
   localparam int RATIO_LSB = 0;
   localparam logic [7:0] MASK_STIM_TMR = 8'h7f;
   localparam logic [7:0] MASK_TH_PD    = 8'h3f;
   localparam logic [7:0] MASK_RATIO    = 8'h07;
   localparam logic [3:0] MAG_RESERVED  = 4'hf;

   // stimulus codes
   localparam logic [2:0] STIM_VBUS_READY = 3'h0;
   localparam logic [2:0] STIM_PLUS_HI    = 3'h1;
   localparam logic [2:0] STIM_PLUS_WIN   = 3'h2;
   localparam logic [2:0] STIM_MINUS_HI   = 3'h3;
   localparam logic [2:0] STIM_PLUS_HI_B  = 3'h6;
   localparam logic [2:0] STIM_VBUS_PRES  = 3'h7;

   // response codes
   localparam logic [3:0] RSP_CLEAR     = 4'h0;
   localparam logic [3:0] RSP_V_PLUS    = 4'h1;
   localparam logic [3:0] RSP_V_MINUS   = 4'h2;
   localparam logic [3:0] RSP_V_BOTH    = 4'h3;
   localparam logic [3:0] RSP_R_PLUS    = 4'h4;
   localparam logic [3:0] RSP_DIV_PLUS  = 4'h6;
   localparam logic [3:0] RSP_R_MINUS   = 4'h7;
   localparam logic [3:0] RSP_DIV_MINUS = 4'h9;
   localparam logic [3:0] RSP_SHORT     = 4'ha;
   localparam logic [3:0] RSP_DIV_BOTH  = 4'hc;
   localparam logic [3:0] RSP_R_BOTH    = 4'hd;
   localparam logic [3:0] RSP_PD_A      = 4'he;
   localparam logic [3:0] RSP_PD_B      = 4'hf;

   typedef struct packed {
      logic plus_pd;
      logic minus_pd;
      logic plus_volt;
      logic minus_volt;
      logic plus_res;
      logic minus_res;
      logic plus_div;
      logic minus_div;
      logic short_pm;
   } cesc_pins_s;

   typedef struct packed {
      logic       timer_type;
      logic [2:0] timer_delay;
      logic [2:0] stim_sel;
      logic [3:0] mag;
      logic [3:0] code;
      logic [1:0] sink;
      logic [3:0] threshold;
   } cesc_stage_s;

   // stage timer in ms per code
   function automatic logic [6:0] timer_ms(input logic [2:0] c);
      logic [6:0] r;
      r = 7'h00;
      unique case (c)
         3'h0: r = 7'd0;
         3'h1: r = 7'd1;
         3'h2: r = 7'd5;
         3'h3: r = 7'd10;
         3'h4: r = 7'd20;
         3'h5: r = 7'd40;
         3'h6: r = 7'd80;
         3'h7: r = 7'd100;
      endcase
      return r;
   endfunction

   // threshold in mV per code, 0 for the reserved code
   function automatic logic [11:0] threshold_mv(input logic [3:0] c);
      logic [11:0] r;
      r = 12'h000;
      unique case (c)
         4'h0, 4'h1, 4'h2, 4'h4: r = 12'd400;
         4'h3: r = 12'd300;
         4'h5: r = 12'd500;
         4'h6: r = 12'd600;
         4'h7: r = 12'd700;
         4'h8: r = 12'd800;
         4'h9: r = 12'd900;
         4'ha: r = 12'd1400;
         4'hb: r = 12'd1600;
         4'hc: r = 12'd1800;
         4'hd: r = 12'd2000;
         4'he: r = 12'd2200;
         4'hf: r = 12'd0;
      endcase
      return r;
   endfunction

   // sink current in uA per code
   function automatic logic [7:0] sink_ua(input logic [1:0] c);
      logic [7:0] r;
      r = 8'h00;
      unique case (c)
         2'h0: r = 8'd10;
         2'h1: r = 8'd50;
         2'h2: r = 8'd100;
         2'h3: r = 8'd150;
      endcase
      return r;
   endfunction

endpackage

// file: cesc_port_model.sv
/*
 * attached device: pin voltages to comparator levels.
 * assumes pin voltages in mV.
 */
`timescale 1ns/1ps
`default_nettype none
module cesc_port_model (
   input  wire logic        clk,
   input  wire logic [11:0] plus_mv,
   input  wire logic [11:0] minus_mv,
   input  wire logic [11:0] th_mv,
   output logic             plus_hi,
   output logic             minus_hi,
   output logic             plus_floor
);
   // ****************
   // comparators
   // ****************
   // one cycle of settling, like a real comparator
   always_ff @(posedge clk)
   begin
      plus_hi    <= plus_mv > th_mv;
      minus_hi   <= minus_mv > th_mv;
      plus_floor <= plus_mv > 12'h190;
   end
endmodule
`default_nettype wire

// file: cesc_top.sv
/*
 * custom emulation stimulus stage pair (stages 2 and 3): configuration
 * registers, stimulus detection, stage timer and data-pin response decode.
 * assumes register access strobes synchronous to CORE_CLK, comparator
 * results from the analog front end, and a start pulse after stage 1.
 */
`timescale 1ns/1ps
`default_nettype none

module cesc_top #(
   parameter int unsigned CYC_PER_MS = cesc_pkg::CYC_PER_MS
) (
   input  wire logic                CORE_CLK,
   input  wire logic                ARST_N,
   input  wire logic [7:0]          REG_ADDR,
   input  wire logic [7:0]          REG_WDATA,
   input  wire logic                REG_WR,
   output logic      [7:0]          REG_RDATA,
   input  wire logic                SEQ_START,
   input  wire logic [2:0]          STAGE1_STIM_SEL,
   input  wire logic                PROFILE_BC12,
   input  wire logic                VBUS_READY,
   input  wire logic                VBUS_PRESENT,
   input  wire logic                PLUS_ABOVE_TH,
   input  wire logic                MINUS_ABOVE_TH,
   input  wire logic                PLUS_ABOVE_FLOOR,
   output cesc_pkg::cesc_pins_s     PIN_CTRL,
   output logic      [3:0]          RESP_MAG,
   output logic      [11:0]         TH_MV,
   output logic      [7:0]          SINK_UA,
   output logic      [2:0]          DIV_RATIO,
   output logic                     STAGE_SEL,
   output logic                     SEQ_DONE
);

   // ****************************************************
   // configuration registers
   // ****************************************************
   logic [7:0] s2_stim_tmr_q;
   logic [7:0] s2_resp_q;
   logic [7:0] s2_th_pd_q;
   logic [7:0] s2_ratio_q;
   logic [7:0] s3_stim_tmr_q;
   logic [7:0] s3_resp_q;
   logic [7:0] s3_th_pd_q;
   logic       mag_ok;

   assign mag_ok = REG_WDATA[cesc_pkg::MAG_LSB +: 4] != cesc_pkg::MAG_RESERVED;

   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         s2_stim_tmr_q <= cesc_pkg::REG_RESET;
         s2_resp_q     <= cesc_pkg::REG_RESET;
         s2_th_pd_q    <= cesc_pkg::REG_RESET;
         s2_ratio_q    <= cesc_pkg::REG_RESET;
         s3_stim_tmr_q <= cesc_pkg::REG_RESET;
         s3_resp_q     <= cesc_pkg::REG_RESET;
         s3_th_pd_q    <= cesc_pkg::REG_RESET;
      end
      else if (REG_WR)
      begin
         unique case (REG_ADDR)
            cesc_pkg::OFS_S2_STIM_TMR: s2_stim_tmr_q <= REG_WDATA & cesc_pkg::MASK_STIM_TMR;
            cesc_pkg::OFS_S2_RESP:     if (mag_ok) s2_resp_q <= REG_WDATA;
            cesc_pkg::OFS_S2_TH_PD:    s2_th_pd_q <= REG_WDATA & cesc_pkg::MASK_TH_PD;
            cesc_pkg::OFS_S2_RATIO:    s2_ratio_q <= REG_WDATA & cesc_pkg::MASK_RATIO;
            cesc_pkg::OFS_S3_STIM_TMR: s3_stim_tmr_q <= REG_WDATA & cesc_pkg::MASK_STIM_TMR;
            cesc_pkg::OFS_S3_RESP:     if (mag_ok) s3_resp_q <= REG_WDATA;
            cesc_pkg::OFS_S3_TH_PD:    s3_th_pd_q <= REG_WDATA & cesc_pkg::MASK_TH_PD;
            default: ;
         endcase
      end
   end

   // read data registered; unmapped addresses read zero
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         REG_RDATA <= 8'h00;
      else
      begin
         unique case (REG_ADDR)
            cesc_pkg::OFS_S2_STIM_TMR: REG_RDATA <= s2_stim_tmr_q;
            cesc_pkg::OFS_S2_RESP:     REG_RDATA <= s2_resp_q;
            cesc_pkg::OFS_S2_TH_PD:    REG_RDATA <= s2_th_pd_q;
            cesc_pkg::OFS_S2_RATIO:    REG_RDATA <= s2_ratio_q;
            cesc_pkg::OFS_S3_STIM_TMR: REG_RDATA <= s3_stim_tmr_q;
            cesc_pkg::OFS_S3_RESP:     REG_RDATA <= s3_resp_q;
            cesc_pkg::OFS_S3_TH_PD:    REG_RDATA <= s3_th_pd_q;
            default:                   REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ****************************************************
   // active stage view
   // ****************************************************
   logic                  stage_q;
   cesc_pkg::cesc_stage_s stg;
   logic [7:0]            stim_tmr;
   logic [7:0]            resp;
   logic [7:0]            th_pd;

   assign stim_tmr = stage_q ? s3_stim_tmr_q : s2_stim_tmr_q;
   assign resp     = stage_q ? s3_resp_q : s2_resp_q;
   assign th_pd    = stage_q ? s3_th_pd_q : s2_th_pd_q;

   always_comb
   begin
      stg.timer_type  = stim_tmr[cesc_pkg::TYPE_BIT];
      stg.timer_delay = stim_tmr[cesc_pkg::TMR_LSB +: 3];
      stg.stim_sel    = stim_tmr[cesc_pkg::STIM_LSB +: 3];
      stg.mag         = resp[cesc_pkg::MAG_LSB +: 4];
      stg.code        = resp[cesc_pkg::CODE_LSB +: 4];
      stg.sink        = th_pd[cesc_pkg::SINK_LSB +: 2];
      stg.threshold   = th_pd[cesc_pkg::TH_LSB +: 4];
   end

   // ****************************************************
   // stimulus detection
   // ****************************************************
   logic stim_hit;

   always_comb
   begin
      unique case (stg.stim_sel)
         cesc_pkg::STIM_VBUS_READY: stim_hit = VBUS_READY;
         cesc_pkg::STIM_VBUS_PRES:  stim_hit = VBUS_PRESENT;
         cesc_pkg::STIM_PLUS_HI,
         cesc_pkg::STIM_PLUS_HI_B:  stim_hit = PLUS_ABOVE_TH;
         cesc_pkg::STIM_MINUS_HI:   stim_hit = MINUS_ABOVE_TH;
         cesc_pkg::STIM_PLUS_WIN:   stim_hit = !PLUS_ABOVE_TH && PLUS_ABOVE_FLOOR;
         default:                   stim_hit = 1'b0;
      endcase
   end

   // ****************************************************
   // response decode
   // ****************************************************
   function automatic logic plus_busy(input cesc_pkg::cesc_pins_s p);
      return p.plus_volt | p.plus_res | p.plus_div | p.short_pm;
   endfunction

   function automatic logic minus_busy(input cesc_pkg::cesc_pins_s p);
      return p.minus_volt | p.minus_res | p.minus_div | p.short_pm;
   endfunction

   function automatic cesc_pkg::cesc_pins_s apply_resp(input cesc_pkg::cesc_pins_s p,
                                                       input logic [3:0]          code,
                                                       input logic [2:0]          stim,
                                                       input logic [2:0]          s1);
      cesc_pkg::cesc_pins_s r;
      logic                 keep_p;
      logic                 keep_m;
      r      = p;
      keep_p = (s1 == cesc_pkg::STIM_VBUS_READY) && !plus_busy(p);
      keep_m = (s1 == cesc_pkg::STIM_VBUS_READY) && !minus_busy(p);
      unique case (code)
         cesc_pkg::RSP_CLEAR:
         begin
            r.plus_volt  = 1'b0;
            r.minus_volt = 1'b0;
            r.plus_res   = 1'b0;
            r.minus_res  = 1'b0;
            r.plus_div   = 1'b0;
            r.minus_div  = 1'b0;
            r.short_pm   = 1'b0;
         end
         cesc_pkg::RSP_V_PLUS:
         begin
            r.plus_volt = 1'b1;
            r.plus_pd   = p.plus_pd & keep_p;
         end
         cesc_pkg::RSP_V_MINUS:
         begin
            r.minus_volt = 1'b1;
            r.minus_pd   = p.minus_pd & keep_m;
         end
         cesc_pkg::RSP_V_BOTH:
         begin
            r.plus_volt  = 1'b1;
            r.minus_volt = 1'b1;
         end
         cesc_pkg::RSP_R_PLUS:
         begin
            r.plus_res = 1'b1;
            r.plus_pd  = p.plus_pd & keep_p;
         end
         cesc_pkg::RSP_R_MINUS:
         begin
            r.minus_res = 1'b1;
            r.minus_pd  = p.minus_pd & keep_m;
         end
         cesc_pkg::RSP_R_BOTH:
         begin
            r.plus_res  = 1'b1;
            r.minus_res = 1'b1;
         end
         cesc_pkg::RSP_DIV_PLUS:
         begin
            r.plus_div = 1'b1;
            r.plus_pd  = p.plus_pd & keep_p;
         end
         cesc_pkg::RSP_DIV_MINUS:
         begin
            r.minus_div = 1'b1;
            r.minus_pd  = p.minus_pd & keep_m;
         end
         cesc_pkg::RSP_DIV_BOTH:
         begin
            r.plus_div  = 1'b1;
            r.minus_div = 1'b1;
         end
         cesc_pkg::RSP_SHORT:
            r.short_pm = 1'b1;
         cesc_pkg::RSP_PD_A,
         cesc_pkg::RSP_PD_B:
         begin
            if (stim == cesc_pkg::STIM_VBUS_PRES)
            begin
               r.plus_pd  = 1'b0;
               r.minus_pd = 1'b0;
            end
         end
         default: ;
      endcase
      return r;
   endfunction

   // ****************************************************
   // sequencer
   // ****************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_DETECT, ST_DELAY, ST_HOLD, ST_DONE} cesc_state_e;

   cesc_state_e          state_q;
   logic [31:0]          tmr_q;
   logic [31:0]          tmr_load;
   cesc_pkg::cesc_pins_s pins_q;
   cesc_pkg::cesc_pins_s saved_q;
   cesc_pkg::cesc_pins_s applied;

   assign tmr_load = 32'(cesc_pkg::timer_ms(stg.timer_delay)) * 32'(CYC_PER_MS);
   assign applied  = apply_resp(pins_q, stg.code, stg.stim_sel, STAGE1_STIM_SEL);

   // stage 2 runs before stage 3; each waits on the previous response
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_q <= ST_IDLE;
         stage_q <= 1'b0;
         tmr_q   <= 32'h0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (SEQ_START)
               begin
                  stage_q <= 1'b0;
                  state_q <= ST_DETECT;
               end
            ST_DETECT:
               if (stim_hit)
               begin
                  tmr_q   <= tmr_load;
                  state_q <= stg.timer_type ? ST_HOLD : ST_DELAY;
               end
            ST_DELAY:
               if (tmr_q == 32'h0)
                  state_q <= stage_q ? ST_DONE : ST_DETECT;
               else
                  tmr_q <= tmr_q - 32'h1;
            ST_HOLD:
               if (tmr_q == 32'h0)
                  state_q <= stage_q ? ST_DONE : ST_DETECT;
               else
                  tmr_q <= tmr_q - 32'h1;
            ST_DONE:
               if (SEQ_START)
               begin
                  stage_q <= 1'b0;
                  state_q <= ST_DETECT;
               end
         endcase
         if ((state_q == ST_DELAY || state_q == ST_HOLD) && tmr_q == 32'h0)
            stage_q <= 1'b1;
      end
   end

   // pin state: reset pull-downs on start, response on delay expiry or
   // at detection for hold type; hold type restores if stimulus is gone
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pins_q  <= '0;
         saved_q <= '0;
      end
      else if (SEQ_START && (state_q == ST_IDLE || state_q == ST_DONE))
      begin
         pins_q          <= '0;
         pins_q.plus_pd  <= 1'b1;
         pins_q.minus_pd <= 1'b1;
      end
      else
      begin
         if (state_q == ST_DETECT && stim_hit && stg.timer_type)
         begin
            saved_q <= pins_q;
            pins_q  <= applied;
         end
         if (state_q == ST_DELAY && tmr_q == 32'h0)
            pins_q <= applied;
         if (state_q == ST_HOLD && tmr_q == 32'h0 && !stim_hit)
            pins_q <= saved_q;
      end
   end

   // ****************************************************
   // analog settings
   // ****************************************************
   localparam logic [2:0] MASK_RATIO3 = cesc_pkg::MASK_RATIO[2:0];

   // profile-gated values freeze rather than follow, so the analog side
   // never sees settings from the wrong profile family
   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         TH_MV     <= 12'h000;
         SINK_UA   <= 8'h00;
         DIV_RATIO <= 3'h0;
         RESP_MAG  <= 4'h0;
      end
      else
      begin
         RESP_MAG <= stg.mag;
         if (PROFILE_BC12)
         begin
            if (stg.stim_sel != cesc_pkg::STIM_VBUS_READY &&
                stg.stim_sel != cesc_pkg::STIM_VBUS_PRES)
               TH_MV <= cesc_pkg::threshold_mv(stg.threshold);
            SINK_UA <= cesc_pkg::sink_ua(stg.sink);
         end
         else if (s2_ratio_q[cesc_pkg::RATIO_LSB +: 3] != MASK_RATIO3)
            DIV_RATIO <= s2_ratio_q[cesc_pkg::RATIO_LSB +: 3];
      end
   end

   assign PIN_CTRL  = pins_q;
   assign STAGE_SEL = stage_q;
   assign SEQ_DONE  = state_q == ST_DONE;

endmodule

`default_nettype wire

// file: tb_cesc_top.sv
/*
 * self-checking bench for cesc_top.
 * assumes package, checker and port model compile first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_cesc_top;
   localparam int CPM = 4;
   logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, start = 1'b0, prof = 1'b0, vrdy = 1'b0, vpres = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, sink;
   logic [2:0] s1sel = 3'h0, ratio;
   logic [11:0] plus_mv = 12'h000, minus_mv = 12'h000, th;
   logic       pa, ma, pf, ssel, done;
   logic [3:0] mag;
   cesc_pkg::cesc_pins_s pins;
   int         err_count = 0, n_compared = 0;
   logic [7:0] ra_t[6] = '{8'h47, 8'h48, 8'h49, 8'h46, 8'h46, 8'h50};
   logic [7:0] rw_t[6] = '{8'hff, 8'hff, 8'hff, 8'h31, 8'hf5, 8'haa};
   logic [7:0] re_t[6] = '{8'h3f, 8'h07, 8'h7f, 8'h31, 8'h31, 8'h00};
   logic [11:0] th_t[15] = '{12'h190, 12'h190, 12'h190, 12'h12c, 12'h190, 12'h1f4, 12'h258, 12'h2bc,
                             12'h320, 12'h384, 12'h578, 12'h640, 12'h708, 12'h7d0, 12'h898};
   logic [11:0] sk_t[4] = '{12'h00a, 12'h032, 12'h064, 12'h096};
   logic [3:0] rc_t[11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'hd, 4'h6, 4'h9, 4'hc, 4'ha};
   logic [6:0] rx_t[11] = '{7'h00, 7'h40, 7'h20, 7'h60, 7'h10, 7'h08, 7'h18, 7'h04, 7'h02, 7'h06, 7'h01};
   logic [2:0] p1_t[5] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0};
   logic [7:0] p2_t[5] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h07};
   logic [7:0] p3_t[5] = '{8'h01, 8'h01, 8'h0e, 8'h0e, 8'h0f};
   logic [1:0] p4_t[5] = '{2'h3, 2'h1, 2'h3, 2'h0, 2'h0};
   logic [2:0] sw_t[4] = '{3'h1, 3'h6, 3'h3, 3'h2};
   logic [11:0] np_t[4] = '{12'h000, 12'h000, 12'h7d0, 12'h7d0};
   logic [11:0] hp_t[4] = '{12'h7d0, 12'h7d0, 12'h000, 12'h3e8};
   logic [11:0] hm_t[4] = '{12'h000, 12'h000, 12'h7d0, 12'h000};
   int         ms_t[4] = '{0, 1, 5, 10};

   always #50 clk = ~clk;

   cesc_top #(.CYC_PER_MS(CPM)) cesc_top_i (
      .CORE_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RDATA(rdata),
      .SEQ_START(start), .STAGE1_STIM_SEL(s1sel), .PROFILE_BC12(prof), .VBUS_READY(vrdy), .VBUS_PRESENT(vpres),
      .PLUS_ABOVE_TH(pa), .MINUS_ABOVE_TH(ma), .PLUS_ABOVE_FLOOR(pf), .PIN_CTRL(pins), .RESP_MAG(mag),
      .TH_MV(th), .SINK_UA(sink), .DIV_RATIO(ratio), .STAGE_SEL(ssel), .SEQ_DONE(done)
   );

   cesc_port_model cesc_port_model_i (
      .clk(clk), .plus_mv(plus_mv), .minus_mv(minus_mv), .th_mv(th), .plus_hi(pa), .minus_hi(ma), .plus_floor(pf)
   );

   // ****************
   // tasks
   // ****************
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // strobe low a cycle between writes
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step();
      wr = 1'b0;
      step();
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      step(2);
      chk("rdata", 12'(e), 12'(rdata));
   endtask

   task automatic pulse();
      start = 1'b1;
      step();
      start = 1'b0;
   endtask

   task automatic wait_for(input int w, output int n);
      n = 0;
      while (n < 300 && (w == 0 ? ssel : w == 1 ? done : pins.plus_volt) !== 1'b1)
      begin
         step();
         n++;
      end
      chk("wait", 12'h001, 12'(n < 300));
   endtask

   // stage 3: minus pin stimulus, clear response
   task automatic finish3();
      int n;
      minus_mv = 12'h7d0;
      wait_for(1, n);
      minus_mv = 12'h000;
      chk("pins", 12'h000, 12'(pins[6:0]));
   endtask

   task automatic complete_run();
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run();
   end

   // ****************
   // main sequence
   // ****************
   initial
   begin
      int n;
      step(2);
      arst_n = 1'b1;
      chk("pins", 12'h000, 12'(pins));
      for (int a = 8'h45; a <= 8'h4b; a++)
         rdc(a[7:0], 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         wrr(ra_t[i], rw_t[i]);
         rdc(ra_t[i], re_t[i]);
      end
      chk("ratio", 12'h000, 12'(ratio));
      prof = 1'b1;
      wrr(8'h45, 8'h01);
      for (int i = 0; i < 15; i++)
      begin
         wrr(8'h47, {2'b00, i[1:0], i[3:0]});
         step();
         chk("th", th_t[i], th);
         chk("sink", sk_t[i % 4], 12'(sink));
      end
      wrr(8'h45, 8'h00);
      wrr(8'h47, 8'h05);
      step();
      chk("th", 12'h898, th);
      prof = 1'b0;
      step();
      wrr(8'h45, 8'h01);
      wrr(8'h47, 8'h13);
      step();
      chk("th", 12'h898, th);
      chk("sink", 12'h00a, 12'(sink));
      for (int i = 0; i < 8; i++)
      begin
         wrr(8'h48, i[7:0]);
         step();
         chk("ratio", 12'(i < 7 ? i : 6), 12'(ratio));
      end
      prof = 1'b1;
      wrr(8'h48, 8'h02);
      step();
      chk("ratio", 12'h006, 12'(ratio));
      wrr(8'h47, 8'h0a);
      wrr(8'h49, 8'h03);
      wrr(8'h4a, 8'h00);
      wrr(8'h4b, 8'h00);
      wrr(8'h45, 8'h00);
      vrdy = 1'b1;
      vpres = 1'b1;
      for (int i = 0; i < 11; i++)
      begin
         wrr(8'h46, {i[3:0], rc_t[i]});
         pulse();
         wait_for(0, n);
         chk("pins", 12'(rx_t[i]), 12'(pins[6:0]));
         chk("mag", 12'(i), 12'(mag));
         finish3();
      end
      for (int i = 0; i < 5; i++)
      begin
         s1sel = p1_t[i];
         wrr(8'h45, p2_t[i]);
         wrr(8'h46, p3_t[i]);
         pulse();
         wait_for(0, n);
         chk("pulldowns", 12'(p4_t[i]), 12'(pins[8:7]));
         finish3();
      end
      s1sel = 3'h0;
      wrr(8'h46, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         plus_mv = np_t[i];
         wrr(8'h45, {5'h00, sw_t[i]});
         pulse();
         step(20);
         chk("stage", 12'h000, 12'(ssel));
         plus_mv = hp_t[i];
         minus_mv = hm_t[i];
         wait_for(0, n);
         plus_mv = 12'h000;
         finish3();
      end
      // last pass holds, then restores
      for (int t = 1; t < 5; t++)
      begin
         wrr(8'h45, t < 4 ? {2'b00, t[2:0], 3'h0} : 8'h58);
         pulse();
         wait_for(2, n);
         chk("delay", 12'h001, 12'(t < 4 ? n == ms_t[t] * CPM + 2 : n == 1));
         vrdy = t < 4;
         wait_for(0, n);
         chk("hold", 12'(t < 4), 12'(pins.plus_volt));
         finish3();
      end
      arst_n = 1'b0;
      step();
      chk("pins", 12'h000, 12'(pins));
      arst_n = 1'b1;
      rdc(8'h46, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
